// ==== hdl/ssp_device.sv ====
`timescale 1ns/1ns
module ssp_device #(
	parameter logic [7:0] SLOT_ADDR = ssp_pkg::SLOT_ADDR_DEF
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	ssp_link_if.device link,
	input wire logic is_cabled_in,
	input wire logic scan_select_in,
	output logic [ssp_pkg::CHAN_W-1:0] mux_channel_out,
	output logic drive_primary_out,
	output logic drive_backplane_out,
	output logic [2:0] gnd_tie_out,
	output logic [ssp_pkg::WORD_W-1:0] config_out
);
	import ssp_pkg::*;

	typedef struct packed {
		logic [2:0] cnt;
		logic [6:0] sh;
		logic addressed;
		logic [7:0] cfg;
		logic tog;
	} ssp_link_st_t;

	typedef struct packed {
		logic [2:0] tog_s;
		logic [2:0] scan_s;
		logic [1:0] cab_s;
		logic [1:0] sel_s;
		logic [7:0] cfg;
		logic [CHAN_W-1:0] chan;
		logic oe_n;
		logic prim;
		logic bp;
		logic [2:0] gnd;
	} ssp_dev_st_t;

	ssp_link_st_t ln_q, ln_d;
	ssp_dev_st_t st_q, st_d;
	logic out_q;
	logic [7:0] word;

	function automatic logic [2:0] gnd_decode(input logic [1:0] sel);
		case (sel)
			GND_PRIMARY: gnd_decode = 3'h1;
			GND_NEG_A: gnd_decode = 3'h2;
			GND_NEG_B: gnd_decode = 3'h4;
			default: gnd_decode = 3'h0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Link side, clocked by the serial clock the host makes.

	always_comb begin
		ln_d = ln_q;
		word = {ln_q.sh, link.serial_in_line};
		if (link.chassis_controller_select_n) begin
			ln_d.cnt = ln_q.cnt + 3'h1;
			ln_d.sh = word[6:0];
			if (ln_q.cnt == 3'h7) begin
				if (link.data_address_qualifier_n) begin
					ln_d.addressed = (word == SLOT_ADDR);
				end else if (ln_q.addressed) begin
					ln_d.cfg = word;
					ln_d.tog = ~ln_q.tog;
				end
			end
		end
	end

	// Inbound bits are taken on the rising edge.
	always_ff @(posedge link.serial_clock_line or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ln_q <= '{cnt: 3'h0, sh: 7'h00, addressed: 1'b0, cfg: CFG_RESET, tog: 1'b0};
		end else begin
			ln_q <= ln_d;
		end
	end

	// Readback changes on the falling edge so the host has a full clock period.
	// The bit shown is the configuration word, MSB first.
	always_ff @(negedge link.serial_clock_line or negedge rst_b_in) begin
		if (!rst_b_in) begin
			out_q <= CFG_RESET[7];
		end else begin
			out_q <= ln_q.cfg[3'h7 - ln_q.cnt];
		end
	end

	assign link.serial_out_drv = out_q;
	assign link.serial_out_oe_n = st_q.oe_n;

	////////////////////////////////////////////////////////////////////////////
	// Module side on clk_in. The config word is held for a whole word time
	// after its toggle, far longer than the toggle takes to cross.

	always_comb begin
		st_d = st_q;
		st_d.tog_s = {st_q.tog_s[1:0], ln_q.tog};
		st_d.scan_s = {st_q.scan_s[1:0], link.scan_advance_clock};
		st_d.cab_s = {st_q.cab_s[0], is_cabled_in};
		st_d.sel_s = {st_q.sel_s[0], scan_select_in};
		if (st_q.tog_s[2] != st_q.tog_s[1]) begin
			st_d.cfg = ln_q.cfg;
			st_d.chan = ln_q.cfg[CFG_START_LSB +: CHAN_W];
		end else if (st_q.scan_s[1] && !st_q.scan_s[2] && st_q.cfg[CFG_SCAN_EN]
				&& st_q.sel_s[1]) begin
			st_d.chan = st_q.chan + 5'h01;
		end
		st_d.oe_n = ~st_q.cab_s[1];
		st_d.prim = st_q.cfg[CFG_SCAN_EN] && st_q.sel_s[1] && st_q.cab_s[1];
		st_d.bp = st_q.cfg[CFG_SCAN_EN] && st_q.sel_s[1] && !st_q.cab_s[1];
		st_d.gnd = gnd_decode(st_q.cfg[CFG_GND_LSB +: CFG_GND_W]);
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= '{tog_s: 3'h0, scan_s: 3'h0, cab_s: 2'h0, sel_s: 2'h0, cfg: CFG_RESET,
				chan: 5'h00, oe_n: 1'b1, prim: 1'b0, bp: 1'b0, gnd: 3'h1};
		end else begin
			st_q <= st_d;
		end
	end

	assign mux_channel_out = st_q.chan;
	assign drive_primary_out = st_q.prim;
	assign drive_backplane_out = st_q.bp;
	assign gnd_tie_out = st_q.gnd;
	assign config_out = st_q.cfg;
endmodule // ssp_device

// ==== hdl/ssp_host.sv ====
`timescale 1ns/1ns
module ssp_host (
	input wire logic clk_in,
	input wire logic rst_b_in,
	ssp_link_if.host link,
	input wire logic req_valid_in,
	input wire logic req_address_in,
	input wire logic req_controller_in,
	input wire logic [ssp_pkg::WORD_W-1:0] req_data_in,
	output logic req_ready_out,
	output logic rsp_valid_out,
	output logic [ssp_pkg::WORD_W-1:0] rsp_data_out,
	input wire logic scan_pulse_in
);
	import ssp_pkg::*;

	typedef struct packed {
		ssp_hstate_t state;
		logic [3:0] div;
		logic [2:0] bitn;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [1:0] rx_s;
		logic sclk;
		logic qual_n;
		logic sel_n;
		logic ready;
		logic rvalid;
		logic [3:0] scan_cnt;
		logic scan;
	} ssp_host_st_t;

	ssp_host_st_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.rx_s = {st_q.rx_s[0], link.serial_out_line};
		st_d.rvalid = 1'b0;
		st_d.div = st_q.div - 4'h1;
		case (st_q.state)
			SSP_IDLE: begin
				st_d.div = SCLK_HALF_CYC;
				if (req_valid_in && st_q.ready) begin
					st_d.state = SSP_LOW;
					st_d.ready = 1'b0;
					st_d.tx = req_data_in;
					st_d.qual_n = req_address_in;
					st_d.sel_n = ~req_controller_in;
					st_d.bitn = 3'h0;
				end
			end
			SSP_LOW: begin
				if (st_q.div == 4'h1) begin
					st_d.state = SSP_HIGH;
					st_d.div = SCLK_HALF_CYC;
					st_d.sclk = 1'b1;
				end
			end
			SSP_HIGH: begin
				if (st_q.div == 4'h1) begin
					// Read data settled a full period ago, at the fall that began this bit's low phase.
					st_d.rx = {st_q.rx[6:0], st_q.rx_s[1]};
					st_d.sclk = 1'b0;
					st_d.div = SCLK_HALF_CYC;
					st_d.tx = {st_q.tx[6:0], 1'b0};
					st_d.bitn = st_q.bitn + 3'h1;
					if (st_q.bitn == 3'h7) begin
						st_d.state = SSP_IDLE;
						st_d.rvalid = 1'b1;
						st_d.ready = 1'b1;
						st_d.sel_n = 1'b1;
						st_d.qual_n = 1'b1;
					end else begin
						st_d.state = SSP_LOW;
					end
				end
			end
			default: st_d.state = SSP_IDLE;
		endcase
		if (scan_pulse_in && !st_q.scan) begin
			st_d.scan = 1'b1;
			st_d.scan_cnt = SCAN_HIGH_CYC;
		end else if (st_q.scan) begin
			st_d.scan_cnt = st_q.scan_cnt - 4'h1;
			st_d.scan = (st_q.scan_cnt != 4'h1);
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= '{state: SSP_IDLE, div: 4'h0, bitn: 3'h0, tx: 8'h00, rx: 8'h00,
				rx_s: 2'h3, sclk: 1'b0, qual_n: 1'b1, sel_n: 1'b1, ready: 1'b1,
				rvalid: 1'b0, scan_cnt: 4'h0, scan: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign link.serial_clock_line = st_q.sclk;
	assign link.serial_in_line = st_q.tx[7];
	assign link.data_address_qualifier_n = st_q.qual_n;
	assign link.chassis_controller_select_n = st_q.sel_n;
	assign link.scan_advance_clock = st_q.scan;
	assign req_ready_out = st_q.ready;
	assign rsp_valid_out = st_q.rvalid;
	assign rsp_data_out = st_q.rx;
endmodule // ssp_host

// ==== hdl/ssp_link_if.sv ====
`timescale 1ns/1ns
interface ssp_link_if;
	logic serial_clock_line;
	logic serial_in_line;
	logic serial_out_drv;
	logic serial_out_oe_n;
	logic serial_out_line;
	logic data_address_qualifier_n;
	logic chassis_controller_select_n;
	logic scan_advance_clock;
	// The out line idles high when no cabled module drives it.
	assign serial_out_line = serial_out_oe_n ? 1'b1 : serial_out_drv;
	modport device (
		input serial_clock_line,
		input serial_in_line,
		output serial_out_drv,
		output serial_out_oe_n,
		input data_address_qualifier_n,
		input chassis_controller_select_n,
		input scan_advance_clock
	);
	modport host (
		output serial_clock_line,
		output serial_in_line,
		input serial_out_line,
		output data_address_qualifier_n,
		output chassis_controller_select_n,
		output scan_advance_clock
	);
endinterface

// ==== hdl/ssp_pkg.sv ====
package ssp_pkg;
	localparam int WORD_W = 8;
	localparam int CHAN_N = 32;
	localparam int CHAN_W = 5;
	localparam int SCAN_LIST_MAX = 512;
	localparam logic [7:0] SLOT_ADDR_DEF = 8'h01;
	// Configuration word fields.
	localparam int CFG_GND_LSB = 0;
	localparam int CFG_GND_W = 2;
	localparam int CFG_SCAN_EN = 2;
	localparam int CFG_START_LSB = 3;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// Ground tie selections; the reset value ties the primary negative line.
	localparam logic [1:0] GND_PRIMARY = 2'h0;
	localparam logic [1:0] GND_NEG_A = 2'h1;
	localparam logic [1:0] GND_NEG_B = 2'h2;
	localparam logic [1:0] GND_NONE = 2'h3;
	// Timing.
	localparam int CLK_NS = 4;
	localparam int SCLK_HALF_NS = 15;
	localparam int SCAN_HIGH_NS = 20;
	localparam logic [3:0] SCLK_HALF_CYC = 4'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] SCAN_HIGH_CYC = 4'((SCAN_HIGH_NS + CLK_NS - 1) / CLK_NS);
	typedef enum logic [1:0] {
		SSP_IDLE = 2'b00,
		SSP_LOW = 2'b01,
		SSP_HIGH = 2'b10
	} ssp_hstate_t;
endpackage

// ==== tb/ssp_link_chk.sv ====
`timescale 1ns/1ns
module ssp_link_chk (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic serial_clock_line,
	input wire logic serial_in_line,
	input wire logic serial_out_drv,
	input wire logic serial_out_oe_n,
	input wire logic serial_out_line,
	input wire logic data_address_qualifier_n,
	input wire logic chassis_controller_select_n,
	input wire logic scan_advance_clock
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	////////////////////////////////////////
	a_sclk_high_time: assert property ($rose(serial_clock_line) |->
		serial_clock_line[*4] ##1 !serial_clock_line) else $error("clock high phase wrong");
	a_sclk_low_time: assert property ($fell(serial_clock_line) |-> !serial_clock_line[*4])
		else $error("clock low phase short");
	a_din_moves_low: assert property (!$stable(serial_in_line) |-> !serial_clock_line)
		else $error("data in moved while clock high");
	a_qual_held: assert property (serial_clock_line |-> $stable(data_address_qualifier_n))
		else $error("qualifier moved inside word");
	a_select_held: assert property (serial_clock_line |-> $stable(chassis_controller_select_n))
		else $error("select moved inside word");
	a_out_idle_high: assert property (serial_out_oe_n |-> serial_out_line)
		else $error("released out line not high");
	// The device moves its bit on the fall itself, so the change is seen inside the low phase.
	a_out_moves_low: assert property ((!$stable(serial_out_drv) && !serial_out_oe_n)
		|-> !serial_clock_line) else $error("out data moved while clock high");
	a_scan_width: assert property ($rose(scan_advance_clock) |->
		scan_advance_clock[*5] ##1 !scan_advance_clock) else $error("scan pulse width wrong");
endmodule // ssp_link_chk

// ==== tb/tb.sv ====
`timescale 1ns/1ns
module tb;
	import ssp_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic cabled = 1'b1;
	logic sel = 1'b1;
	logic vld = 1'b0;
	logic adr = 1'b0;
	logic ctl = 1'b0;
	logic scan = 1'b0;
	logic [7:0] din = 8'h00;
	logic rdy, rv, prim, bp;
	logic [7:0] rd, cfg;
	logic [4:0] ch;
	logic [2:0] gnd;
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	ssp_link_if link ();
	ssp_device i_ssp_device (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link.device),
		.is_cabled_in(cabled), .scan_select_in(sel), .mux_channel_out(ch),
		.drive_primary_out(prim), .drive_backplane_out(bp), .gnd_tie_out(gnd), .config_out(cfg));
	ssp_host i_ssp_host (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link.host),
		.req_valid_in(vld), .req_address_in(adr), .req_controller_in(ctl), .req_data_in(din),
		.req_ready_out(rdy), .rsp_valid_out(rv), .rsp_data_out(rd), .scan_pulse_in(scan));
	ssp_link_chk i_ssp_link_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.serial_clock_line(link.serial_clock_line), .serial_in_line(link.serial_in_line),
		.serial_out_drv(link.serial_out_drv), .serial_out_oe_n(link.serial_out_oe_n),
		.serial_out_line(link.serial_out_line),
		.data_address_qualifier_n(link.data_address_qualifier_n),
		.chassis_controller_select_n(link.chassis_controller_select_n),
		.scan_advance_clock(link.scan_advance_clock));
	////////////////////////////////////////
	initial forever #2 clk_in = ~clk_in;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Waits a few cycles after the answer, since the device copy lags the last clock rise.
	task automatic send(input logic a, input logic c, input logic [7:0] d, output logic [7:0] r);
		int n;
		n = 0;
		@(posedge clk_in);
		vld <= 1'b1;
		adr <= a;
		ctl <= c;
		din <= d;
		@(posedge clk_in);
		vld <= 1'b0;
		do begin
			@(posedge clk_in);
			#1;
			n++;
		end while (rv !== 1'b1 && n < 100);
		check(8'(rv), 8'h01);
		r = rd;
		repeat (6) @(posedge clk_in);
	endtask
	task automatic pulse();
		@(posedge clk_in);
		scan <= 1'b1;
		@(posedge clk_in);
		scan <= 1'b0;
		repeat (14) @(posedge clk_in);
		#1;
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	////////////////////////////////////////
	initial begin
		logic [7:0] r;
		repeat (20) @(posedge clk_in);
		rst_b_in <= 1'b1;
		#1;
		check(8'(gnd), 8'h01);
		check(8'(ch), 8'h00);
		for (int i = 0; i < 4; i++) begin
			send(1'b1, 1'b0, 8'h01, r);
			check(r, 8'(i == 0 ? 0 : i - 1));
			send(1'b0, 1'b0, 8'(i), r);
			check(cfg, 8'(i));
			check(8'(gnd), 8'(i == 3 ? 0 : 1 << i));
		end
		$display("test ground done");
		// A word for the chassis controller stands in for its scan list load.
		send(1'b0, 1'b1, 8'hFF, r);
		check(cfg, 8'h03);
		send(1'b1, 1'b0, 8'h02, r);
		check(r, 8'h03);
		send(1'b0, 1'b0, 8'h55, r);
		check(cfg, 8'h03);
		$display("test select done");
		send(1'b1, 1'b0, 8'h01, r);
		send(1'b0, 1'b0, 8'hF4, r);
		check(8'(ch), 8'h1E);
		check(8'({prim, bp}), 8'h02);
		pulse();
		check(8'(ch), 8'h1F);
		pulse();
		check(8'(ch), 8'h00);
		check(8'(CHAN_N <= SCAN_LIST_MAX), 8'h01);
		@(posedge clk_in);
		sel <= 1'b0;
		pulse();
		check(8'(ch), 8'h00);
		check(8'({prim, bp}), 8'h00);
		@(posedge clk_in);
		sel <= 1'b1;
		cabled <= 1'b0;
		repeat (8) @(posedge clk_in);
		#1;
		check(8'({prim, bp}), 8'h01);
		$display("test scan done");
		wrap_up();
	end
endmodule // tb
